// *** iex_core.sv ***
`timescale 1ns/100ps
module iex_core (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Command
   input wire logic cmdValid,
   input wire iex_pkg::iex_cmd_t cmd,
   output logic cmdReady,
   output logic done,
   // Data memory
   output iex_pkg::iex_mem_req_t memReq,
   input wire iex_pkg::iex_mem_rsp_t memRsp,
   // Register view
   input wire logic [iex_pkg::IEX_RIDX_W-1:0] viewSel,
   output logic [iex_pkg::IEX_XLEN-1:0] viewData
);
   import iex_pkg::*;

   typedef enum logic [2:0] {
      IEX_ST_IDLE = 3'b001,
      IEX_ST_EXEC = 3'b010,
      IEX_ST_MEM = 3'b100
   } iex_state_t;

   iex_state_t state;
   iex_cmd_t cur;
   logic secondWord;
   logic [IEX_XLEN-1:0] regs [IEX_NREGS];

   // Command completion
   logic lastAck, finishing;

   // Operands and addresses
   logic [IEX_XLEN-1:0] opA, regB, opB, dispX, dataEa, codeEa, opBx;
   logic [IEX_RIDX_W-1:0] rxHi;

   // Arithmetic results
   logic [IEX_XLEN:0] carrySum;
   logic carryOvf;
   logic [2*IEX_XLEN-1:0] wideProd, wideDividend, wideQuot, wideResid;
   logic [IEX_XLEN-1:0] sQuot, sResid, residFix;
   logic divZero;

   // Register write ports
   logic wrEnA, wrEnB;
   logic [IEX_RIDX_W-1:0] wrIdxA, wrIdxB;
   logic [IEX_XLEN-1:0] wrDataA, wrDataB;

   // Immediate substitution applies only to the forms that have one
   function automatic logic immAllowed(input iex_op_t op);
      return op inside {IEX_MOVE, IEX_NOT, IEX_ADD, IEX_SUBTRACT, IEX_AND, IEX_INTEGER_PRODUCT};
   endfunction : immAllowed

   function automatic logic isMemOp(input iex_op_t op);
      return op inside {IEX_BYTE_FETCH, IEX_HALFWORD_FETCH, IEX_WORD_FETCH, IEX_DOUBLEWORD_FETCH,
         IEX_BYTE_WRITE, IEX_HALFWORD_WRITE, IEX_WORD_WRITE, IEX_DOUBLEWORD_WRITE};
   endfunction : isMemOp

   function automatic logic isWriteOp(input iex_op_t op);
      return op inside {IEX_BYTE_WRITE, IEX_HALFWORD_WRITE, IEX_WORD_WRITE, IEX_DOUBLEWORD_WRITE};
   endfunction : isWriteOp

   function automatic logic isPairOp(input iex_op_t op);
      return op inside {IEX_DOUBLEWORD_FETCH, IEX_DOUBLEWORD_WRITE};
   endfunction : isPairOp

   // Register zero flag word: carry and overflow, every other bit cleared
   function automatic logic [IEX_XLEN-1:0] flagWord(input logic carry, input logic ovf);
      logic [IEX_XLEN-1:0] w;
      w = IEX_WORD_ZERO;
      w[IEX_CARRY_BIT] = carry;
      w[IEX_OVF_BIT] = ovf;
      return w;
   endfunction : flagWord

   function automatic iex_size_t opSize(input iex_op_t op);
      case (op)
         IEX_BYTE_FETCH, IEX_BYTE_WRITE: return IEX_SZ_BYTE;
         IEX_HALFWORD_FETCH, IEX_HALFWORD_WRITE: return IEX_SZ_HALF;
         default: return IEX_SZ_WORD;
      endcase
   endfunction : opSize

   // Keeps the element lanes, zeroes the rest; shared by loads and stores
   function automatic logic [IEX_XLEN-1:0] laneKeep(input iex_size_t sz, input logic [IEX_XLEN-1:0] d);
      case (sz)
         IEX_SZ_BYTE: return {{(IEX_XLEN-IEX_BYTE_W){1'b0}}, d[IEX_BYTE_W-1:0]};
         IEX_SZ_HALF: return {{(IEX_XLEN-IEX_HALF_W){1'b0}}, d[IEX_HALF_W-1:0]};
         default: return d;
      endcase
   endfunction : laneKeep

   // Operand and address forming
   always_comb begin
      opA = regs[cur.rx];
      regB = regs[cur.secondRegister];
      opB = (cur.imm && immAllowed(cur.op)) ?
         {{(IEX_XLEN-IEX_RIDX_W){1'b0}}, cur.secondRegister} : regB;
      dispX = cur.shortDisp ?
         {{(IEX_XLEN-IEX_SDISP_W){cur.disp[IEX_SDISP_W-1]}}, cur.disp[IEX_SDISP_W-1:0]} : cur.disp;
      dataEa = cur.indexed ? regB + dispX : dispX;
      codeEa = cur.pc + (cur.indexed ? regB : IEX_WORD_ZERO) + dispX;
      // Pair index wraps from the last register to register zero
      rxHi = cur.rx + IEX_PAIR_STEP;
   end

   // Carry chain adder, shared by the add and subtract forms
   always_comb begin
      opBx = (cur.op == IEX_CARRY_CHAIN_SUBTRACT) ? ~opB : opB;
      carrySum = {1'b0, opA} + {1'b0, opBx} +
         {{IEX_XLEN{1'b0}}, regs[IEX_ZERO_REG][IEX_CARRY_BIT]};
      // Signed overflow: equal operand signs but a different result sign
      carryOvf = (opA[IEX_XLEN-1] == opBx[IEX_XLEN-1]) && (carrySum[IEX_XLEN-1] != opA[IEX_XLEN-1]);
   end

   // Multiplier and dividers
   always_comb begin
      wideProd = {{IEX_XLEN{1'b0}}, opA} * {{IEX_XLEN{1'b0}}, opB};
      wideDividend = {opA, regs[rxHi]};
      // A zero divisor is masked so no undefined quotient reaches the registers
      divZero = (opB == IEX_WORD_ZERO);
      wideQuot = divZero ? {2*IEX_XLEN{1'b0}} : wideDividend / {{IEX_XLEN{1'b0}}, opB};
      wideResid = divZero ? {2*IEX_XLEN{1'b0}} : wideDividend % {{IEX_XLEN{1'b0}}, opB};
      sQuot = divZero ? IEX_WORD_ZERO : IEX_XLEN'($signed(opA) / $signed(opB));
      sResid = divZero ? IEX_WORD_ZERO : IEX_XLEN'($signed(opA) % $signed(opB));
      // Truncating remainder follows the dividend; move it to the divisor's sign
      residFix = (sResid != IEX_WORD_ZERO && sResid[IEX_XLEN-1] != opB[IEX_XLEN-1]) ?
         sResid + opB : sResid;
   end

   // Register write ports; port A is applied last so it wins over R0 flags
   always_comb begin
      wrEnA = 1'b0;
      wrEnB = 1'b0;
      wrIdxA = cur.rx;
      wrIdxB = IEX_ZERO_REG;
      wrDataA = IEX_WORD_ZERO;
      wrDataB = IEX_WORD_ZERO;
      if (state == IEX_ST_EXEC) begin
         wrEnA = 1'b1;
         case (cur.op)
            IEX_ADDRESS_FORM: wrDataA = dataEa;
            IEX_CODE_RELATIVE_ADDRESS_FORM: wrDataA = codeEa;
            IEX_ADD: wrDataA = opA + opB;
            IEX_SUBTRACT: wrDataA = opA - opB;
            IEX_INTEGER_PRODUCT: wrDataA = wideProd[IEX_XLEN-1:0];
            IEX_DIVIDE: begin
               wrEnA = !divZero;
               wrDataA = sQuot;
            end
            IEX_INTEGER_REMAINDER: begin
               wrEnA = !divZero;
               wrDataA = residFix;
            end
            IEX_INTEGER_NEGATE: wrDataA = IEX_WORD_ZERO - opB;
            IEX_AND: wrDataA = opA & opB;
            IEX_OR: wrDataA = opA | opB;
            IEX_XOR: wrDataA = opA ^ opB;
            IEX_NOT: wrDataA = ~opB;
            IEX_MOVE: wrDataA = opB;
            IEX_CARRY_CHAIN_ADD, IEX_CARRY_CHAIN_SUBTRACT: begin
               wrDataA = carrySum[IEX_XLEN-1:0];
               wrEnB = 1'b1;
               wrDataB = flagWord(carrySum[IEX_XLEN], carryOvf);
            end
            IEX_WIDE_QUOTIENT: begin
               wrEnA = !divZero;
               wrDataA = wideQuot[IEX_XLEN-1:0];
               wrEnB = !divZero;
               wrIdxB = cur.secondRegister;
               wrDataB = wideResid[IEX_XLEN-1:0];
            end
            IEX_WIDE_PRODUCT: begin
               wrDataA = wideProd[2*IEX_XLEN-1:IEX_XLEN];
               wrEnB = 1'b1;
               wrIdxB = rxHi;
               wrDataB = wideProd[IEX_XLEN-1:0];
            end
            default: wrEnA = 1'b0;
         endcase
      end else if (state == IEX_ST_MEM && memRsp.ack && !memReq.write) begin
         wrEnA = 1'b1;
         wrIdxA = secondWord ? rxHi : cur.rx;
         wrDataA = laneKeep(memReq.size, memRsp.rdata);
      end
   end

   // Register file
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < IEX_NREGS; i++) begin
            regs[i] <= IEX_WORD_ZERO;
         end
      end else begin
         if (wrEnB) begin
            regs[wrIdxB] <= wrDataB;
         end
         if (wrEnA) begin
            regs[wrIdxA] <= wrDataA;
         end
      end
   end

   // Last acknowledge of the access and completion of any command
   always_comb begin
      lastAck = memRsp.ack && (secondWord || !isPairOp(cur.op));
      finishing = (state == IEX_ST_EXEC && !isMemOp(cur.op)) || (state == IEX_ST_MEM && lastAck);
   end

   // Sequencing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= IEX_ST_IDLE;
      end else begin
         case (state)
            IEX_ST_IDLE: begin
               if (cmdValid) begin
                  state <= IEX_ST_EXEC;
               end
            end
            IEX_ST_EXEC: begin
               if (isMemOp(cur.op)) begin
                  state <= IEX_ST_MEM;
               end else begin
                  state <= IEX_ST_IDLE;
               end
            end
            IEX_ST_MEM: begin
               if (lastAck) begin
                  state <= IEX_ST_IDLE;
               end
            end
            default: begin
               state <= IEX_ST_IDLE;
            end
         endcase
      end
   end

   // Command capture; the held copy drives the whole execution
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur <= '0;
      end else if (state == IEX_ST_IDLE && cmdValid) begin
         cur <= cmd;
      end
   end

   // Ready rises with done, so a new command may be taken in the done cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmdReady <= 1'b1;
      end else if (state == IEX_ST_IDLE && cmdValid) begin
         cmdReady <= 1'b0;
      end else if (finishing || !(state inside {IEX_ST_IDLE, IEX_ST_EXEC, IEX_ST_MEM})) begin
         cmdReady <= 1'b1;
      end
   end

   // One-cycle completion pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done <= 1'b0;
      end else begin
         done <= finishing;
      end
   end

   // Memory request; held until acknowledged, second word follows directly
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         memReq <= '0;
      end else begin
         if (state == IEX_ST_EXEC && isMemOp(cur.op)) begin
            memReq.req <= 1'b1;
            memReq.write <= isWriteOp(cur.op);
            memReq.size <= opSize(cur.op);
            memReq.addr <= dataEa;
            memReq.wdata <= laneKeep(opSize(cur.op), opA);
         end else if (state == IEX_ST_MEM && memRsp.ack) begin
            if (!lastAck) begin
               memReq.addr <= memReq.addr + IEX_WORD_STEP;
               memReq.wdata <= regs[rxHi];
            end else begin
               memReq.req <= 1'b0;
            end
         end
      end
   end

   // Pair phase: set by the first acknowledge of a doubleword access
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         secondWord <= 1'b0;
      end else if (state == IEX_ST_EXEC) begin
         secondWord <= 1'b0;
      end else if (state == IEX_ST_MEM && memRsp.ack) begin
         secondWord <= !lastAck;
      end
   end

   // Register view for observation
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         viewData <= IEX_WORD_ZERO;
      end else begin
         viewData <= regs[viewSel];
      end
   end
endmodule : iex_core

// *** iex_pkg.sv ***
// Summary of operation
// - Byte load fills low byte, clears rest
// - Halfword load fills low half, clears rest
// - Word moves one register; doubleword moves two
// - Byte store writes only the low byte
// - Halfword store writes only the low half
// - Address form writes address, no memory access
// - Code address form adds PC, index, displacement
// - Immediate mode uses field as 0..15 constant
// - Add sums two's complement operands into first
// - Divide writes signed quotient into first
// - Multiply keeps low 32 product bits
// - Negate writes two's complement of second
// - Remainder takes the divisor's sign
// - Subtract writes first minus second
// - AND, OR, XOR, NOT, MOVE on registers
// - No-operation changes no register
// - Immediate variants mirror register forms
// - Carry add updates carry, overflow in R0
// - Carry subtract adds complement plus carry
// - Wide divide: pair by second, quotient, remainder
// - Wide multiply writes 64-bit product to pair
// - Pair is named register and next one
// - Indexed address is index plus displacement
// - Short displacement is sign extended
package iex_pkg;
   localparam int IEX_XLEN = 32;
   localparam int IEX_RIDX_W = 4;
   localparam int IEX_NREGS = 16;
   localparam int IEX_BYTE_W = 8;
   localparam int IEX_HALF_W = 16;
   localparam int IEX_SDISP_W = 16;
   // Bit 31 of the big-endian numbering is the LSB here
   localparam int IEX_CARRY_BIT = 0;
   localparam int IEX_OVF_BIT = 1;
   localparam logic [31:0] IEX_WORD_STEP = 32'h0000_0004;
   localparam logic [31:0] IEX_WORD_ZERO = 32'h0000_0000;
   localparam logic [3:0] IEX_ZERO_REG = 4'h0;
   localparam logic [3:0] IEX_PAIR_STEP = 4'h1;

   typedef enum logic [4:0] {
      IEX_NOP, IEX_BYTE_FETCH, IEX_HALFWORD_FETCH, IEX_WORD_FETCH, IEX_DOUBLEWORD_FETCH,
      IEX_BYTE_WRITE, IEX_HALFWORD_WRITE, IEX_WORD_WRITE, IEX_DOUBLEWORD_WRITE,
      IEX_ADDRESS_FORM, IEX_CODE_RELATIVE_ADDRESS_FORM,
      IEX_ADD, IEX_SUBTRACT, IEX_INTEGER_PRODUCT, IEX_DIVIDE, IEX_INTEGER_REMAINDER,
      IEX_INTEGER_NEGATE, IEX_AND, IEX_OR, IEX_XOR, IEX_NOT, IEX_MOVE,
      IEX_CARRY_CHAIN_ADD, IEX_CARRY_CHAIN_SUBTRACT, IEX_WIDE_QUOTIENT, IEX_WIDE_PRODUCT
   } iex_op_t;

   typedef enum logic [1:0] {IEX_SZ_BYTE, IEX_SZ_HALF, IEX_SZ_WORD} iex_size_t;

   typedef struct packed {
      iex_op_t op;
      logic [IEX_RIDX_W-1:0] rx;
      logic [IEX_RIDX_W-1:0] secondRegister;
      logic imm;
      logic indexed;
      logic shortDisp;
      logic [IEX_XLEN-1:0] disp;
      logic [IEX_XLEN-1:0] pc;
   } iex_cmd_t;

   typedef struct packed {
      logic req;
      logic write;
      iex_size_t size;
      logic [IEX_XLEN-1:0] addr;
      logic [IEX_XLEN-1:0] wdata;
   } iex_mem_req_t;

   typedef struct packed {
      logic ack;
      logic [IEX_XLEN-1:0] rdata;
   } iex_mem_rsp_t;
endpackage : iex_pkg

// *** iex_monitor.sv ***
`timescale 1ns/100ps
module iex_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Command
   input wire logic cmdValid,
   input wire iex_pkg::iex_cmd_t cmd,
   input wire logic cmdReady,
   input wire logic done,
   // Memory
   input wire iex_pkg::iex_mem_req_t memReq,
   input wire iex_pkg::iex_mem_rsp_t memRsp
);
   import iex_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic take;
   logic isMem;
   logic [31:0] ea;
   assign take = cmdValid && cmdReady;
   assign isMem = cmd.op >= IEX_BYTE_FETCH && cmd.op <= IEX_DOUBLEWORD_WRITE;
   // Direct form only: indexed addresses depend on register contents
   assign ea = cmd.shortDisp ? {{16{cmd.disp[15]}}, cmd.disp[15:0]} : cmd.disp;
   a_done_pulse: assert property (done |=> !done) else $error("done wider than one cycle");
   a_take_busy: assert property (take |=> !cmdReady && !done) else $error("ready after take");
   a_reg_latency: assert property (take && !isMem |-> ##1 !done ##1 done)
      else $error("register op latency wrong");
   a_addr_quiet: assert property (take && cmd.op inside {IEX_ADDRESS_FORM, IEX_CODE_RELATIVE_ADDRESS_FORM}
      |-> !memReq.req [*3]) else $error("address form touched memory");
   a_req_hold: assert property (memReq.req && !memRsp.ack |=> memReq.req && $stable(memReq.addr)
      && $stable(memReq.wdata)) else $error("request moved before ack");
   a_byte_data: assert property (memReq.req && memReq.write && memReq.size == IEX_SZ_BYTE
      |-> memReq.wdata[31:8] == 24'h00_0000) else $error("byte store upper bits");
   a_half_data: assert property (memReq.req && memReq.write && memReq.size == IEX_SZ_HALF
      |-> memReq.wdata[31:16] == 16'h0000) else $error("half store upper bits");
   a_direct_ea: assert property (take && isMem && !cmd.indexed
      |-> ##2 memReq.req && memReq.addr == $past(ea, 2)) else $error("direct address wrong");
endmodule : iex_monitor

// *** iex_mem_model.sv ***
`timescale 1ns/100ps
module iex_mem_model (
   // Clock and pace
   input wire logic clk,
   input wire logic slow,
   // Memory port
   input wire iex_pkg::iex_mem_req_t memReq,
   output iex_pkg::iex_mem_rsp_t memRsp
);
   import iex_pkg::*;
   logic [31:0] mem [16];
   logic hold;
   initial begin
      memRsp = '0;
      hold = 1'b0;
      for (int i = 0; i < 16; i++) mem[i] = 32'h5A5A_0000 + i;
   end
   always @(posedge clk) begin
      hold <= ~hold;
      memRsp.ack <= memReq.req && !memRsp.ack && (!slow || hold);
      // Idle bus toggles so a stale word never passes for a reply
      memRsp.rdata <= (memReq.req && !memRsp.ack) ? mem[memReq.addr[5:2]] : ~memRsp.rdata;
      if (memReq.req && memRsp.ack && memReq.write) mem[memReq.addr[5:2]] <= memReq.wdata;
   end
endmodule : iex_mem_model

// *** integer_execute_load_store_test.sv ***
`timescale 1ns/100ps
module integer_execute_load_store_test;
   import iex_pkg::*;
   logic clk, rst, cmdValid, slow, cmdReady, done;
   iex_cmd_t cmd;
   iex_mem_req_t memReq;
   iex_mem_rsp_t memRsp;
   logic [3:0] viewSel;
   logic [31:0] viewData;
   int bad_count, total_checks, cycles;
   iex_core i_dut (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady), .done(done),
      .memReq(memReq), .memRsp(memRsp), .viewSel(viewSel), .viewData(viewData));
   iex_mem_model i_mem (.clk(clk), .slow(slow), .memReq(memReq), .memRsp(memRsp));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic op(iex_op_t o, logic [3:0] x, logic [3:0] y, logic [31:0] d = 32'h0, logic im = 0,
      logic ix = 0, logic sd = 0);
      int n;
      @(negedge clk);
      cmdValid = 1'b1;
      cmd = '{o, x, y, im, ix, sd, d, 32'h0000_0100};
      @(negedge clk);
      cmdValid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      if (n == 50) check(32'h1, 32'h0);
   endtask : op
   task automatic chk(logic [3:0] r, logic [31:0] exp);
      viewSel = r;
      @(negedge clk);
      check(viewData, exp);
   endtask : chk
   function automatic logic [31:0] ref_alu(iex_op_t o, logic signed [31:0] a, logic signed [31:0] b);
      logic signed [31:0] r;
      r = a % b;
      case (o)
         IEX_ADD: return a + b;
         IEX_SUBTRACT: return a - b;
         IEX_INTEGER_PRODUCT: return a * b;
         IEX_DIVIDE: return a / b;
         IEX_INTEGER_NEGATE: return -b;
         IEX_AND: return a & b;
         IEX_OR: return a | b;
         IEX_XOR: return a ^ b;
         IEX_NOT: return ~b;
         IEX_MOVE: return b;
         default: return (r != 0 && r[31] != b[31]) ? r + b : r;
      endcase
   endfunction : ref_alu
   task automatic t_alu;
      iex_op_t ops[17] = '{IEX_ADD, IEX_SUBTRACT, IEX_INTEGER_PRODUCT, IEX_DIVIDE, IEX_INTEGER_REMAINDER,
         IEX_INTEGER_NEGATE, IEX_AND, IEX_OR, IEX_XOR, IEX_NOT, IEX_MOVE, IEX_MOVE, IEX_NOT, IEX_ADD,
         IEX_SUBTRACT, IEX_AND, IEX_INTEGER_PRODUCT};
      for (int i = 0; i < 17; i++) begin
         op(IEX_ADDRESS_FORM, 1, 0, 32'hFFFF_FFF9);
         op(IEX_ADDRESS_FORM, 2, 0, 32'h0000_0005);
         op(ops[i], 1, 2, 32'h0, i > 10);
         chk(1, ref_alu(ops[i], 32'hFFFF_FFF9, i > 10 ? 32'h2 : 32'h5));
      end
   endtask : t_alu
   task automatic t_misc;
      op(IEX_ADDRESS_FORM, 1, 0, 32'h1234_5678);
      op(IEX_ADDRESS_FORM, 2, 0, 32'h0);
      op(IEX_NOP, 1, 2);
      op(IEX_DIVIDE, 1, 2);
      op(IEX_INTEGER_REMAINDER, 1, 2);
      op(IEX_WIDE_QUOTIENT, 1, 2);
      chk(1, 32'h1234_5678);
   endtask : t_misc
   task automatic t_carry;
      logic [31:0] av[4] = '{32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h0000_0005, 32'h0000_0003};
      logic [31:0] bv[4] = '{32'h0000_0001, 32'h0, 32'h0000_0003, 32'h0000_0005};
      logic [3:0] cv = 4'hE;
      logic [31:0] b, s;
      logic c, v;
      for (int i = 0; i < 4; i++) begin
         b = i > 1 ? ~bv[i] : bv[i];
         {c, s} = {1'b0, av[i]} + {1'b0, b} + {32'h0, cv[i]};
         v = av[i][31] == b[31] && s[31] != av[i][31];
         op(IEX_ADDRESS_FORM, 0, 0, {31'h0, cv[i]});
         op(IEX_ADDRESS_FORM, 3, 0, av[i]);
         op(IEX_ADDRESS_FORM, 4, 0, bv[i]);
         op(i > 1 ? IEX_CARRY_CHAIN_SUBTRACT : IEX_CARRY_CHAIN_ADD, 3, 4);
         chk(3, s);
         chk(0, {30'h0, v, c});
      end
   endtask : t_carry
   task automatic t_wide;
      op(IEX_ADDRESS_FORM, 6, 0, 32'hFFFF_FFFF);
      op(IEX_ADDRESS_FORM, 8, 0, 32'hFFFF_FFFF);
      op(IEX_WIDE_PRODUCT, 6, 8);
      chk(6, 32'hFFFF_FFFE);
      chk(7, 32'h0000_0001);
      op(IEX_ADDRESS_FORM, 8, 0, 32'h0000_0010);
      op(IEX_WIDE_QUOTIENT, 6, 8);
      chk(6, 32'hE000_0000);
      chk(8, 32'h0000_0001);
   endtask : t_wide
   task automatic t_mem(logic s);
      logic [31:0] r1, r2;
      r1 = s ? 32'h3501_0FF2 : 32'hCAFE_F00D;
      r2 = s ? 32'h2468_ACE0 : 32'h1357_9BDF;
      slow = s;
      op(IEX_ADDRESS_FORM, 1, 0, r1);
      op(IEX_ADDRESS_FORM, 2, 0, r2);
      op(IEX_ADDRESS_FORM, 3, 0, 32'h0000_0020);
      // Every memory access below is word aligned
      op(IEX_WORD_WRITE, 1, 0, 32'h0000_0008);
      check(i_mem.mem[2], r1);
      op(IEX_DOUBLEWORD_WRITE, 1, 3, 32'h0000_FFEC, 0, 1, 1);
      check(i_mem.mem[3], r1);
      check(i_mem.mem[4], r2);
      op(IEX_BYTE_WRITE, 2, 0, 32'h0000_0014);
      check(i_mem.mem[5], {24'h0, r2[7:0]});
      op(IEX_HALFWORD_WRITE, 2, 0, 32'h0000_0018);
      check(i_mem.mem[6], {16'h0, r2[15:0]});
      op(IEX_DOUBLEWORD_FETCH, 8, 0, 32'h0000_000C);
      chk(8, r1);
      chk(9, r2);
      op(IEX_BYTE_FETCH, 10, 0, 32'h0000_0010);
      chk(10, {24'h0, r2[7:0]});
      op(IEX_HALFWORD_FETCH, 11, 0, 32'h0000_0010);
      chk(11, {16'h0, r2[15:0]});
      op(IEX_WORD_FETCH, 12, 3, 32'h0000_FFE8, 0, 1, 1);
      chk(12, r1);
      op(IEX_CODE_RELATIVE_ADDRESS_FORM, 13, 3, 32'h0000_0004, 0, 1);
      chk(13, 32'h0000_0124);
      op(IEX_ADDRESS_FORM, 14, 3, 32'h0000_FFFF, 0, 1, 1);
      chk(14, 32'h0000_001F);
   endtask : t_mem
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      rst = 1'b1;
      cmdValid = 1'b0;
      cmd = '0;
      viewSel = 4'h0;
      slow = 1'b0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_alu();
      t_misc();
      t_carry();
      t_wide();
      t_mem(1'b0);
      t_mem(1'b1);
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      chk(1, 32'h0);
      print_verdict();
   end
endmodule : integer_execute_load_store_test
bind iex_core iex_monitor i_mon (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady),
   .done(done), .memReq(memReq), .memRsp(memRsp));
